// ==== core/accr_dec.sv ====
// Address decoder turning bus writes into one-hot register write strobes.
module accr_dec
  import accr_pkg::*;
(
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  accr_wr_if.src wr
);

  // ==========================================================================
  // Write decode
  // ==========================================================================
  always_comb begin
    wr.wr_hit = 6'h0;
    if (!wr_en) begin
      wr.wr_hit = 6'h0;
    end else if (addr == ACCR_CHAN3_OFFSET_LOW) begin
      wr.wr_hit[0] = 1'b1;
    end else if (addr == ACCR_CHAN3_GAIN_HIGH) begin
      wr.wr_hit[1] = 1'b1;
    end else if (addr == ACCR_CHAN3_GAIN_LOW) begin
      wr.wr_hit[2] = 1'b1;
    end else if (addr == ACCR_CHAN4_CONFIG) begin
      wr.wr_hit[3] = 1'b1;
    end else if (addr == ACCR_CHAN4_OFFSET_HIGH) begin
      wr.wr_hit[4] = 1'b1;
    end else if (addr == ACCR_CHAN4_OFFSET_LOW) begin
      wr.wr_hit[5] = 1'b1;
    end
    wr.wdata = wdata;
  end

endmodule

// ==== core/accr_pkg.sv ====
// Package with register map, field layout and reset values of the calibration register slice.
package accr_pkg;

  // ==========================================================================
  // Bus widths
  // ==========================================================================
  localparam int ACCR_ADDR_W = 8;
  localparam int ACCR_DATA_W = 16;
  localparam int ACCR_CAL_W = 24;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] ACCR_CHAN3_OFFSET_LOW = 8'h1a;
  localparam logic [7:0] ACCR_CHAN3_GAIN_HIGH = 8'h1b;
  localparam logic [7:0] ACCR_CHAN3_GAIN_LOW = 8'h1c;
  localparam logic [7:0] ACCR_CHAN4_CONFIG = 8'h1d;
  localparam logic [7:0] ACCR_CHAN4_OFFSET_HIGH = 8'h1e;
  localparam logic [7:0] ACCR_CHAN4_OFFSET_LOW = 8'h1f;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] ACCR_RST_GAIN_HIGH = 16'h8000;
  localparam logic [15:0] ACCR_RST_ZERO = 16'h0000;
  localparam logic [7:0] ACCR_RST_BYTE = 8'h00;
  localparam logic [9:0] ACCR_RST_PHASE = 10'h000;
  localparam logic [1:0] ACCR_RST_SEL = 2'h0;
  localparam logic [15:0] ACCR_UNMAPPED_READ = 16'h0000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int ACCR_LOW_BYTE_MSB = 15;
  localparam int ACCR_LOW_BYTE_LSB = 8;
  localparam int ACCR_PHASE_MSB = 15;
  localparam int ACCR_PHASE_LSB = 6;
  localparam int ACCR_CFG_RSV_MSB = 5;
  localparam int ACCR_CFG_RSV_LSB = 3;
  localparam int ACCR_DCBLK_BIT = 2;
  localparam int ACCR_SEL_MSB = 1;
  localparam int ACCR_SEL_LSB = 0;

  // ==========================================================================
  // Input selector encoding
  // ==========================================================================
  typedef enum logic [1:0] {
    ACCR_SEL_PINS = 2'h0,
    ACCR_SEL_SHORT = 2'h1,
    ACCR_SEL_POS_TEST = 2'h2,
    ACCR_SEL_NEG_TEST = 2'h3
  } accr_sel_t;

endpackage

// ==== core/accr_regs.sv ====
// Calibration and configuration register slice for channels three and four.
//
// Chosen here: the address-and-strobe port.

module accr_regs
  import accr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic global_dc_block_setting,
  output logic [23:0] chan3_offset,
  output logic [23:0] chan3_gain,
  output logic [23:0] chan4_offset,
  output logic [9:0] chan4_phase_delay,
  output logic chan4_dc_block_active,
  output logic chan4_use_pins,
  output logic chan4_inputs_shorted,
  output logic chan4_pos_test,
  output logic chan4_neg_test
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Only the writable bits are stored, so reserved bits cannot hold state.
  logic [7:0] chan3_offset_low_byte_ff;
  logic [7:0] nxt_chan3_offset_low_byte;
  logic [15:0] chan3_gain_high_word_ff;
  logic [15:0] nxt_chan3_gain_high_word;
  logic [7:0] chan3_gain_low_byte_ff;
  logic [7:0] nxt_chan3_gain_low_byte;
  logic [9:0] chan4_phase_delay_ff;
  logic [9:0] nxt_chan4_phase_delay;
  logic chan4_dc_block_off_ff;
  logic nxt_chan4_dc_block_off;
  accr_sel_t chan4_input_select_ff;
  accr_sel_t nxt_chan4_input_select;
  logic [15:0] chan4_offset_high_word_ff;
  logic [15:0] nxt_chan4_offset_high_word;
  logic [7:0] chan4_offset_low_byte_ff;
  logic [7:0] nxt_chan4_offset_low_byte;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  // Channel three offset high word sits outside this slice; its bits come in
  // as zero here and the datapath merges the upper part elsewhere.
  logic [15:0] chan3_offset_high_word;

  accr_wr_if wr ();

  accr_dec u_dec (
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .wr(wr)
  );

  assign chan3_offset_high_word = ACCR_RST_ZERO;

  // ==========================================================================
  // Next-state for register fields
  // ==========================================================================
  always_comb begin
    nxt_chan3_offset_low_byte = chan3_offset_low_byte_ff;
    nxt_chan3_gain_high_word = chan3_gain_high_word_ff;
    nxt_chan3_gain_low_byte = chan3_gain_low_byte_ff;
    nxt_chan4_phase_delay = chan4_phase_delay_ff;
    nxt_chan4_dc_block_off = chan4_dc_block_off_ff;
    nxt_chan4_input_select = chan4_input_select_ff;
    nxt_chan4_offset_high_word = chan4_offset_high_word_ff;
    nxt_chan4_offset_low_byte = chan4_offset_low_byte_ff;
    if (wr.wr_hit[0]) begin
      nxt_chan3_offset_low_byte = wr.wdata[ACCR_LOW_BYTE_MSB:ACCR_LOW_BYTE_LSB];
    end
    if (wr.wr_hit[1]) begin
      nxt_chan3_gain_high_word = wr.wdata;
    end
    if (wr.wr_hit[2]) begin
      nxt_chan3_gain_low_byte = wr.wdata[ACCR_LOW_BYTE_MSB:ACCR_LOW_BYTE_LSB];
    end
    if (wr.wr_hit[3]) begin
      // Bits 5:3 of the written word are dropped here.
      nxt_chan4_phase_delay = wr.wdata[ACCR_PHASE_MSB:ACCR_PHASE_LSB];
      nxt_chan4_dc_block_off = wr.wdata[ACCR_DCBLK_BIT];
      nxt_chan4_input_select = accr_sel_t'(wr.wdata[ACCR_SEL_MSB:ACCR_SEL_LSB]);
    end
    if (wr.wr_hit[4]) begin
      nxt_chan4_offset_high_word = wr.wdata;
    end
    if (wr.wr_hit[5]) begin
      nxt_chan4_offset_low_byte = wr.wdata[ACCR_LOW_BYTE_MSB:ACCR_LOW_BYTE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chan3_offset_low_byte_ff <= ACCR_RST_BYTE;
      chan3_gain_high_word_ff <= ACCR_RST_GAIN_HIGH;
      chan3_gain_low_byte_ff <= ACCR_RST_BYTE;
      chan4_phase_delay_ff <= ACCR_RST_PHASE;
      chan4_dc_block_off_ff <= 1'b0;
      chan4_input_select_ff <= ACCR_SEL_PINS;
      chan4_offset_high_word_ff <= ACCR_RST_ZERO;
      chan4_offset_low_byte_ff <= ACCR_RST_BYTE;
    end else if (clk_en) begin
      chan3_offset_low_byte_ff <= nxt_chan3_offset_low_byte;
      chan3_gain_high_word_ff <= nxt_chan3_gain_high_word;
      chan3_gain_low_byte_ff <= nxt_chan3_gain_low_byte;
      chan4_phase_delay_ff <= nxt_chan4_phase_delay;
      chan4_dc_block_off_ff <= nxt_chan4_dc_block_off;
      chan4_input_select_ff <= nxt_chan4_input_select;
      chan4_offset_high_word_ff <= nxt_chan4_offset_high_word;
      chan4_offset_low_byte_ff <= nxt_chan4_offset_low_byte;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Read data is registered and valid only in the cycle after the strobe.
  always_comb begin
    nxt_rdata = ACCR_UNMAPPED_READ;
    if (!rd_en) begin
      nxt_rdata = ACCR_UNMAPPED_READ;
    end else if (addr == ACCR_CHAN3_OFFSET_LOW) begin
      nxt_rdata = {chan3_offset_low_byte_ff, ACCR_RST_BYTE};
    end else if (addr == ACCR_CHAN3_GAIN_HIGH) begin
      nxt_rdata = chan3_gain_high_word_ff;
    end else if (addr == ACCR_CHAN3_GAIN_LOW) begin
      nxt_rdata = {chan3_gain_low_byte_ff, ACCR_RST_BYTE};
    end else if (addr == ACCR_CHAN4_CONFIG) begin
      nxt_rdata = {chan4_phase_delay_ff, 3'b000, chan4_dc_block_off_ff,
                   chan4_input_select_ff};
    end else if (addr == ACCR_CHAN4_OFFSET_HIGH) begin
      nxt_rdata = chan4_offset_high_word_ff;
    end else if (addr == ACCR_CHAN4_OFFSET_LOW) begin
      nxt_rdata = {chan4_offset_low_byte_ff, ACCR_RST_BYTE};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= ACCR_RST_ZERO;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ==========================================================================
  // Datapath views
  // ==========================================================================
  // Offsets are two's complement: high word carries the sign in bit 23.
  assign chan3_offset = {chan3_offset_high_word, chan3_offset_low_byte_ff};
  assign chan4_offset = {chan4_offset_high_word_ff, chan4_offset_low_byte_ff};
  // Gain is an unsigned 1.23 fraction: 800000h means exactly one.
  assign chan3_gain = {chan3_gain_high_word_ff, chan3_gain_low_byte_ff};
  assign chan4_phase_delay = chan4_phase_delay_ff;
  // A set disable bit overrides the global enable for this channel alone.
  assign chan4_dc_block_active = global_dc_block_setting & ~chan4_dc_block_off_ff;

  always_comb begin
    chan4_use_pins = 1'b0;
    chan4_inputs_shorted = 1'b0;
    chan4_pos_test = 1'b0;
    chan4_neg_test = 1'b0;
    case (chan4_input_select_ff)
      ACCR_SEL_PINS: chan4_use_pins = 1'b1;
      ACCR_SEL_SHORT: chan4_inputs_shorted = 1'b1;
      ACCR_SEL_POS_TEST: chan4_pos_test = 1'b1;
      default: chan4_neg_test = 1'b1;
    endcase
  end

endmodule

// ==== core/accr_wr_if.sv ====
// Interface carrying decoded write strobes and data from the decoder to the storage.
interface accr_wr_if;
  import accr_pkg::*;
  logic [5:0] wr_hit;
  logic [15:0] wdata;
  modport src (output wr_hit, output wdata);
  modport dst (input wr_hit, input wdata);
endinterface

// ==== tb/accr_regs_props.sv ====
// Concurrent checks on the ports of the calibration register slice.
module accr_regs_props
  import accr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  input wire logic global_dc_block_setting,
  input wire logic [23:0] chan3_offset,
  input wire logic [23:0] chan3_gain,
  input wire logic [23:0] chan4_offset,
  input wire logic [9:0] chan4_phase_delay,
  input wire logic chan4_dc_block_active,
  input wire logic chan4_use_pins,
  input wire logic chan4_inputs_shorted,
  input wire logic chan4_pos_test,
  input wire logic chan4_neg_test
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Accepted bus requests
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a); clk_en && wr_en && addr == a; endsequence
  sequence s_rd(logic [7:0] a); clk_en && rd_en && addr == a; endsequence
  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_rst; $fell(rst) |-> chan3_gain == 24'h80_0000 && chan4_use_pins; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_gh; s_wr(8'h1b) |=> chan3_gain[23:8] == $past(wdata); endproperty
  a_gh: assert property (p_gh) else $error("gain high word");
  property p_gl; s_wr(8'h1c) |=> chan3_gain[7:0] == $past(wdata[15:8]); endproperty
  a_gl: assert property (p_gl) else $error("gain low byte");
  property p_ph; s_wr(8'h1d) |=> chan4_phase_delay == $past(wdata[15:6]); endproperty
  a_ph: assert property (p_ph) else $error("phase field");
  property p_dc;
    s_wr(8'h1d) |=> chan4_dc_block_active == (global_dc_block_setting && !$past(wdata[2]));
  endproperty
  a_dc: assert property (p_dc) else $error("dc block control");
  property p_sel; s_wr(8'h1d) |=> {chan4_neg_test, chan4_pos_test, chan4_inputs_shorted,
    chan4_use_pins} == 4'h1 << $past(wdata[1:0]); endproperty
  a_sel: assert property (p_sel) else $error("input select");
  property p_rl; s_rd(8'h1a) or s_rd(8'h1c) or s_rd(8'h1f) |=> rdata[7:0] == 8'h00; endproperty
  a_rl: assert property (p_rl) else $error("reserved byte");
  property p_rc; s_rd(8'h1d) |=> rdata[5:3] == 3'h0; endproperty
  a_rc: assert property (p_rc) else $error("reserved config bits");
endmodule
bind accr_regs accr_regs_props accr_regs_props_inst (.clk(clk), .rst(rst), .clk_en(clk_en),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .global_dc_block_setting(global_dc_block_setting), .chan3_offset(chan3_offset),
  .chan3_gain(chan3_gain), .chan4_offset(chan4_offset), .chan4_phase_delay(chan4_phase_delay),
  .chan4_dc_block_active(chan4_dc_block_active), .chan4_use_pins(chan4_use_pins),
  .chan4_inputs_shorted(chan4_inputs_shorted), .chan4_pos_test(chan4_pos_test),
  .chan4_neg_test(chan4_neg_test));

// ==== tb/accr_regs_tb.sv ====
// Self-checking testbench for the calibration register slice.
module accr_regs_tb
  import accr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus and design
  // ==========================================================================
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0, dc_glob = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [23:0] c3_off, c3_gain, c4_off;
  logic [9:0] phase;
  logic dc_act;
  wire [3:0] sel_oh;
  int fails = 0, n_compared = 0;
  logic [7:0] adr_t [6] = '{8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f};
  logic [15:0] msk_t [6] = '{16'hff00, 16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00};
  always #20 clk = ~clk;
  accr_regs accr_regs_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .global_dc_block_setting(dc_glob),
    .chan3_offset(c3_off), .chan3_gain(c3_gain), .chan4_offset(c4_off),
    .chan4_phase_delay(phase), .chan4_dc_block_active(dc_act), .chan4_use_pins(sel_oh[0]),
    .chan4_inputs_shorted(sel_oh[1]), .chan4_pos_test(sel_oh[2]), .chan4_neg_test(sel_oh[3]));
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled just past that edge.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic chk_rst();
    for (int i = 0; i < 6; i++) rd(adr_t[i], i == 1 ? 16'h8000 : 16'h0000);
    `CHK({c3_gain, sel_oh}, {24'h80_0000, 4'h1})
    $display("test reset_values done");
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk_rst();
    for (int i = 0; i < 6; i++) wr(adr_t[i], 16'hffff);
    for (int i = 0; i < 6; i++) rd(adr_t[i], msk_t[i]);
    `CHK({c3_off, c4_off, phase}, {24'h00_00ff, 24'hff_ffff, 10'h3ff})
    $display("test reserved_bits done");
    wr(8'h1e, 16'h1234);
    wr(8'h1f, 16'habcd);
    wr(8'h1b, 16'ha5c3);
    wr(8'h1c, 16'h5a7e);
    wr(8'h1a, 16'h8100);
    #1;
    `CHK(c4_off, 24'h12_34ab)
    `CHK(c3_gain, 24'ha5_c35a)
    `CHK(c3_off, 24'h00_0081)
    $display("test field_mapping done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) dc_glob <= i[0];
      wr(8'h1d, {10'h2aa, 3'h7, i[1], i[1:0]});
      #1;
      `CHK({phase, dc_act, sel_oh}, {10'h2aa, i[0] & ~i[1], 4'(1 << i)})
      rd(8'h1d, {10'h2aa, 3'h0, i[1], i[1:0]});
    end
    $display("test config_modes done");
    wr(8'h19, 16'h5555);
    wr(8'h20, 16'h5555);
    rd(8'h19, 16'h0000);
    rd(8'h1a, 16'h8100);
    @(posedge clk) clk_en <= 1'b0;
    wr(8'h1e, 16'hdead);
    @(posedge clk) clk_en <= 1'b1;
    rd(8'h1e, 16'h1234);
    $display("test unmapped_and_hold done");
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    chk_rst();
    end_sim();
  end
  // A stuck run is cut short and judged as a mismatch.
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule
